// ---- rtl/clock_gating_pkg.sv ----
// Constants, types and helpers shared by the clock-gating control block
package clock_gating_pkg;

  // ***************************************************************
  // Bus geometry
  // ***************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SEL_W  = 4;
  localparam int BYTE_W = 8;
  localparam int WORD_LSB = 2;

  // ***************************************************************
  // Register offsets (byte addresses)
  // ***************************************************************
  localparam logic [ADDR_W-1:0] RUN_GATE_0_OFFSET   = 12'h100;
  localparam logic [ADDR_W-1:0] RUN_GATE_1_OFFSET   = 12'h104;
  localparam logic [ADDR_W-1:0] SLEEP_GATE_0_OFFSET = 12'h110;
  localparam logic [ADDR_W-1:0] SLEEP_GATE_1_OFFSET = 12'h114;
  localparam logic [ADDR_W-1:0] DEEP_GATE_0_OFFSET  = 12'h120;
  localparam logic [ADDR_W-1:0] DEEP_GATE_1_OFFSET  = 12'h124;
  localparam logic [ADDR_W-1:0] MODE_CTRL_OFFSET    = 12'h200;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET       = 12'h204;

  // ***************************************************************
  // Reset values and writable masks
  // ***************************************************************
  localparam logic [DATA_W-1:0] GATE_0_RESET    = 32'h00000040;
  localparam logic [DATA_W-1:0] GATE_1_RESET    = 32'h00000000;
  localparam logic [DATA_W-1:0] MODE_CTRL_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] GATE_0_MASK     = 32'h07000008;
  localparam logic [DATA_W-1:0] GATE_1_MASK     = 32'h000F1031;
  localparam logic [DATA_W-1:0] MODE_CTRL_MASK  = 32'h00000001;
  localparam logic [DATA_W-1:0] ZERO_WORD       = 32'h00000000;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int FIELDBUS0_BIT   = 24;
  localparam int FIELDBUS1_BIT   = 25;
  localparam int FIELDBUS2_BIT   = 26;
  localparam int WATCHDOG_BIT    = 3;
  localparam int GP_GP_TIMER_UNIT0_CLOCK_ENABLE_BIT   = 16;
  localparam int GP_GP_TIMER_UNIT1_CLOCK_ENABLE_BIT   = 17;
  localparam int GP_GP_TIMER_UNIT2_CLOCK_ENABLE_BIT   = 18;
  localparam int GP_GP_TIMER_UNIT3_CLOCK_ENABLE_BIT   = 19;
  localparam int TWO_WIRE0_BIT   = 12;
  localparam int SYNC_SERIAL0_BIT  = 4;
  localparam int SYNC_SERIAL1_BIT  = 5;
  localparam int ASYNC_SERIAL0_BIT = 0;
  localparam int AUTO_GATING_BIT = 0;
  localparam int STATUS_MODE_LSB = 16;
  localparam int UNIT_COUNT      = 12;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP_SLEEP
  } power_mode_t;

  typedef enum logic [3:0] {
    UNIT_FIELDBUS0,
    UNIT_FIELDBUS1,
    UNIT_FIELDBUS2,
    UNIT_WATCHDOG,
    UNIT_GP_GP_TIMER_UNIT0_CLOCK_ENABLE,
    UNIT_GP_GP_TIMER_UNIT1_CLOCK_ENABLE,
    UNIT_GP_GP_TIMER_UNIT2_CLOCK_ENABLE,
    UNIT_GP_GP_TIMER_UNIT3_CLOCK_ENABLE,
    UNIT_TWO_WIRE0,
    UNIT_SYNC_SERIAL0,
    UNIT_SYNC_SERIAL1,
    UNIT_ASYNC_SERIAL0
  } unit_id_t;

  // Bit order follows unit_id_t, unit 0 in the lsb
  typedef logic [UNIT_COUNT-1:0] unit_enables_t;

  typedef struct packed {
    logic [DATA_W-1:0] word1;
    logic [DATA_W-1:0] word0;
  } gate_set_t;

  // Pull the per-unit enables out of one gate register pair
  function automatic unit_enables_t unpack_enables(input gate_set_t s);
    unit_enables_t e;
    e = '0;
    e[UNIT_FIELDBUS0]     = s.word0[FIELDBUS0_BIT];
    e[UNIT_FIELDBUS1]     = s.word0[FIELDBUS1_BIT];
    e[UNIT_FIELDBUS2]     = s.word0[FIELDBUS2_BIT];
    e[UNIT_WATCHDOG]      = s.word0[WATCHDOG_BIT];
    e[UNIT_GP_GP_TIMER_UNIT0_CLOCK_ENABLE]     = s.word1[GP_GP_TIMER_UNIT0_CLOCK_ENABLE_BIT];
    e[UNIT_GP_GP_TIMER_UNIT1_CLOCK_ENABLE]     = s.word1[GP_GP_TIMER_UNIT1_CLOCK_ENABLE_BIT];
    e[UNIT_GP_GP_TIMER_UNIT2_CLOCK_ENABLE]     = s.word1[GP_GP_TIMER_UNIT2_CLOCK_ENABLE_BIT];
    e[UNIT_GP_GP_TIMER_UNIT3_CLOCK_ENABLE]     = s.word1[GP_GP_TIMER_UNIT3_CLOCK_ENABLE_BIT];
    e[UNIT_TWO_WIRE0]     = s.word1[TWO_WIRE0_BIT];
    e[UNIT_SYNC_SERIAL0]  = s.word1[SYNC_SERIAL0_BIT];
    e[UNIT_SYNC_SERIAL1]  = s.word1[SYNC_SERIAL1_BIT];
    e[UNIT_ASYNC_SERIAL0] = s.word1[ASYNC_SERIAL0_BIT];
    return e;
  endfunction : unpack_enables

endpackage : clock_gating_pkg

// ---- rtl/gate_register.sv ----
// One 32-bit control register with byte lanes and a writable-bit mask
module gate_register #(
  parameter logic [31:0] RESET_VALUE = 32'h00000000,
  parameter logic [31:0] WRITE_MASK  = 32'hFFFFFFFF
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        write_en,
  input  wire logic [3:0]  byte_sel,
  input  wire logic [31:0] write_data,
  output logic      [31:0] value
);

  logic [31:0] stored;
  logic [31:0] lane_mask;

  always_comb begin
    for (int i = 0; i < clock_gating_pkg::SEL_W; i++) begin
      lane_mask[i*clock_gating_pkg::BYTE_W +: clock_gating_pkg::BYTE_W] =
        {clock_gating_pkg::BYTE_W{byte_sel[i]}};
    end
  end

  // ***************************************************************
  // Storage
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stored <= RESET_VALUE;
    end else if (write_en) begin
      stored <= (stored & ~lane_mask) | (write_data & lane_mask);
    end
  end

  // Reserved bits never leave the register, so they read as zero
  assign value = stored & WRITE_MASK;

endmodule : gate_register

// ---- rtl/unit_access_check.sv ----
// Grants or faults a bus access aimed at one gated peripheral unit
module unit_access_check (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_b,
  input  wire clock_gating_pkg::unit_enables_t enables,
  input  wire logic                            access_valid,
  input  wire clock_gating_pkg::unit_id_t      access_id,
  output logic                                 access_fault,
  output logic                                 access_grant
);

  logic target_on;

  // Codes past the last unit have no clock at all
  always_comb begin
    target_on = 1'b0;
    if (access_id <= clock_gating_pkg::UNIT_ASYNC_SERIAL0) begin
      target_on = enables[access_id];
    end
  end

  // ***************************************************************
  // One-cycle answer per request
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      access_fault <= 1'b0;
      access_grant <= 1'b0;
    end else begin
      access_fault <= access_valid & ~target_on;
      access_grant <= access_valid & target_on;
    end
  end

endmodule : unit_access_check

// ---- rtl/peripheral_clock_gating.sv ----
// Clock-gating control registers and per-unit clock enables
//
// Design decision made here: the Wishbone slave port.
module peripheral_clock_gating (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [11:0]                   wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  output logic                               wb_err_o,
  input  wire clock_gating_pkg::power_mode_t power_mode,
  input  wire logic                          unit_access_valid,
  input  wire clock_gating_pkg::unit_id_t    unit_access_id,
  output logic                               unit_access_fault,
  output logic                               unit_access_grant,
  output logic                               fieldbus_unit0_clock_enable,
  output logic                               fieldbus_unit1_clock_enable,
  output logic                               fieldbus_unit2_clock_enable,
  output logic                               watchdog_clock_enable,
  output logic                               gp_timer_unit0_clock_enable,
  output logic                               gp_timer_unit1_clock_enable,
  output logic                               gp_timer_unit2_clock_enable,
  output logic                               gp_timer_unit3_clock_enable,
  output logic                               two_wire_unit0_clock_enable,
  output logic                               sync_serial_unit0_clock_enable,
  output logic                               sync_serial_unit1_clock_enable,
  output logic                               async_serial_unit0_clock_enable
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic                            request;
  logic                            mapped;
  logic                            take_write;
  logic [31:0]                     read_word;
  logic [31:0]                     run_clock_gate_0;
  logic [31:0]                     run_clock_gate_1;
  logic [31:0]                     sleep_clock_gate_0;
  logic [31:0]                     sleep_clock_gate_1;
  logic [31:0]                     deep_sleep_clock_gate_0;
  logic [31:0]                     deep_sleep_clock_gate_1;
  logic [31:0]                     run_clock_config;
  logic [31:0]                     status_word;
  logic                            auto_gating_select;
  clock_gating_pkg::gate_set_t     run_set;
  clock_gating_pkg::gate_set_t     sleep_set;
  clock_gating_pkg::gate_set_t     deep_set;
  clock_gating_pkg::gate_set_t     next_set;
  clock_gating_pkg::unit_enables_t next_enables;
  clock_gating_pkg::unit_enables_t enables;
  clock_gating_pkg::power_mode_t   applied_mode;

  // ***************************************************************
  // Address decode
  // ***************************************************************
  function automatic logic hits(input logic [11:0] adr,
                                input logic [11:0] offset);
    return adr[11:clock_gating_pkg::WORD_LSB] ==
           offset[11:clock_gating_pkg::WORD_LSB];
  endfunction : hits

  assign request = wb_cyc_i & wb_stb_i;

  always_comb begin
    mapped = hits(wb_adr_i, clock_gating_pkg::RUN_GATE_0_OFFSET)
           | hits(wb_adr_i, clock_gating_pkg::RUN_GATE_1_OFFSET)
           | hits(wb_adr_i, clock_gating_pkg::SLEEP_GATE_0_OFFSET)
           | hits(wb_adr_i, clock_gating_pkg::SLEEP_GATE_1_OFFSET)
           | hits(wb_adr_i, clock_gating_pkg::DEEP_GATE_0_OFFSET)
           | hits(wb_adr_i, clock_gating_pkg::DEEP_GATE_1_OFFSET)
           | hits(wb_adr_i, clock_gating_pkg::MODE_CTRL_OFFSET)
           | hits(wb_adr_i, clock_gating_pkg::STATUS_OFFSET);
  end

  // Writes land on the edge where the master samples ack
  assign take_write = request & wb_we_i & wb_ack_o;

  // ***************************************************************
  // Run set
  // ***************************************************************
  gate_register #(
    .RESET_VALUE (clock_gating_pkg::GATE_0_RESET),
    .WRITE_MASK  (clock_gating_pkg::GATE_0_MASK)
  ) u_run_gate_0 (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .write_en   (take_write &
                 hits(wb_adr_i, clock_gating_pkg::RUN_GATE_0_OFFSET)),
    .byte_sel   (wb_sel_i),
    .write_data (wb_dat_i),
    .value      (run_clock_gate_0)
  );

  gate_register #(
    .RESET_VALUE (clock_gating_pkg::GATE_1_RESET),
    .WRITE_MASK  (clock_gating_pkg::GATE_1_MASK)
  ) u_run_gate_1 (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .write_en   (take_write &
                 hits(wb_adr_i, clock_gating_pkg::RUN_GATE_1_OFFSET)),
    .byte_sel   (wb_sel_i),
    .write_data (wb_dat_i),
    .value      (run_clock_gate_1)
  );

  // ***************************************************************
  // Sleep set
  // ***************************************************************
  gate_register #(
    .RESET_VALUE (clock_gating_pkg::GATE_0_RESET),
    .WRITE_MASK  (clock_gating_pkg::GATE_0_MASK)
  ) u_sleep_gate_0 (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .write_en   (take_write &
                 hits(wb_adr_i, clock_gating_pkg::SLEEP_GATE_0_OFFSET)),
    .byte_sel   (wb_sel_i),
    .write_data (wb_dat_i),
    .value      (sleep_clock_gate_0)
  );

  gate_register #(
    .RESET_VALUE (clock_gating_pkg::GATE_1_RESET),
    .WRITE_MASK  (clock_gating_pkg::GATE_1_MASK)
  ) u_sleep_gate_1 (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .write_en   (take_write &
                 hits(wb_adr_i, clock_gating_pkg::SLEEP_GATE_1_OFFSET)),
    .byte_sel   (wb_sel_i),
    .write_data (wb_dat_i),
    .value      (sleep_clock_gate_1)
  );

  // ***************************************************************
  // Deep-sleep set
  // ***************************************************************
  // Bit 6 of the reset value is outside the writable mask: reads zero
  gate_register #(
    .RESET_VALUE (clock_gating_pkg::GATE_0_RESET),
    .WRITE_MASK  (clock_gating_pkg::GATE_0_MASK)
  ) u_deep_gate_0 (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .write_en   (take_write &
                 hits(wb_adr_i, clock_gating_pkg::DEEP_GATE_0_OFFSET)),
    .byte_sel   (wb_sel_i),
    .write_data (wb_dat_i),
    .value      (deep_sleep_clock_gate_0)
  );

  gate_register #(
    .RESET_VALUE (clock_gating_pkg::GATE_1_RESET),
    .WRITE_MASK  (clock_gating_pkg::GATE_1_MASK)
  ) u_deep_gate_1 (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .write_en   (take_write &
                 hits(wb_adr_i, clock_gating_pkg::DEEP_GATE_1_OFFSET)),
    .byte_sel   (wb_sel_i),
    .write_data (wb_dat_i),
    .value      (deep_sleep_clock_gate_1)
  );

  // ***************************************************************
  // Mode control
  // ***************************************************************
  gate_register #(
    .RESET_VALUE (clock_gating_pkg::MODE_CTRL_RESET),
    .WRITE_MASK  (clock_gating_pkg::MODE_CTRL_MASK)
  ) u_mode_ctrl (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .write_en   (take_write &
                 hits(wb_adr_i, clock_gating_pkg::MODE_CTRL_OFFSET)),
    .byte_sel   (wb_sel_i),
    .write_data (wb_dat_i),
    .value      (run_clock_config)
  );

  assign auto_gating_select =
    run_clock_config[clock_gating_pkg::AUTO_GATING_BIT];

  // ***************************************************************
  // Set selection
  // ***************************************************************
  assign run_set   = '{word1: run_clock_gate_1, word0: run_clock_gate_0};
  assign sleep_set = '{word1: sleep_clock_gate_1,
                       word0: sleep_clock_gate_0};
  assign deep_set  = '{word1: deep_sleep_clock_gate_1,
                       word0: deep_sleep_clock_gate_0};

  // Without auto gating the run set stays in force in every mode
  always_comb begin
    next_set = run_set;
    if (auto_gating_select) begin
      unique case (power_mode)
        clock_gating_pkg::MODE_RUN:        next_set = run_set;
        clock_gating_pkg::MODE_SLEEP:      next_set = sleep_set;
        clock_gating_pkg::MODE_DEEP_SLEEP: next_set = deep_set;
        default:                           next_set = run_set;
      endcase
    end
    next_enables = clock_gating_pkg::unpack_enables(next_set);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      enables <= '0;
    end else begin
      enables <= next_enables;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      applied_mode <= clock_gating_pkg::MODE_RUN;
    end else if (auto_gating_select) begin
      applied_mode <= power_mode;
    end else begin
      applied_mode <= clock_gating_pkg::MODE_RUN;
    end
  end

  // ***************************************************************
  // Unit clock enables
  // ***************************************************************
  always_comb begin
    fieldbus_unit0_clock_enable =
      enables[clock_gating_pkg::UNIT_FIELDBUS0];
    fieldbus_unit1_clock_enable =
      enables[clock_gating_pkg::UNIT_FIELDBUS1];
    fieldbus_unit2_clock_enable =
      enables[clock_gating_pkg::UNIT_FIELDBUS2];
    watchdog_clock_enable =
      enables[clock_gating_pkg::UNIT_WATCHDOG];
    gp_timer_unit0_clock_enable =
      enables[clock_gating_pkg::UNIT_GP_GP_TIMER_UNIT0_CLOCK_ENABLE];
    gp_timer_unit1_clock_enable =
      enables[clock_gating_pkg::UNIT_GP_GP_TIMER_UNIT1_CLOCK_ENABLE];
    gp_timer_unit2_clock_enable =
      enables[clock_gating_pkg::UNIT_GP_GP_TIMER_UNIT2_CLOCK_ENABLE];
    gp_timer_unit3_clock_enable =
      enables[clock_gating_pkg::UNIT_GP_GP_TIMER_UNIT3_CLOCK_ENABLE];
    two_wire_unit0_clock_enable =
      enables[clock_gating_pkg::UNIT_TWO_WIRE0];
    sync_serial_unit0_clock_enable =
      enables[clock_gating_pkg::UNIT_SYNC_SERIAL0];
    sync_serial_unit1_clock_enable =
      enables[clock_gating_pkg::UNIT_SYNC_SERIAL1];
    async_serial_unit0_clock_enable =
      enables[clock_gating_pkg::UNIT_ASYNC_SERIAL0];
  end

  // ***************************************************************
  // Peripheral access fault
  // ***************************************************************
  unit_access_check u_access_check (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .enables      (enables),
    .access_valid (unit_access_valid),
    .access_id    (unit_access_id),
    .access_fault (unit_access_fault),
    .access_grant (unit_access_grant)
  );

  // ***************************************************************
  // Read data
  // ***************************************************************
  always_comb begin
    status_word = clock_gating_pkg::ZERO_WORD;
    status_word[clock_gating_pkg::UNIT_COUNT-1:0] = enables;
    status_word[clock_gating_pkg::STATUS_MODE_LSB +: 2] = applied_mode;
  end

  always_comb begin
    read_word = clock_gating_pkg::ZERO_WORD;
    if (hits(wb_adr_i, clock_gating_pkg::RUN_GATE_0_OFFSET)) begin
      read_word = run_clock_gate_0;
    end
    if (hits(wb_adr_i, clock_gating_pkg::RUN_GATE_1_OFFSET)) begin
      read_word = run_clock_gate_1;
    end
    if (hits(wb_adr_i, clock_gating_pkg::SLEEP_GATE_0_OFFSET)) begin
      read_word = sleep_clock_gate_0;
    end
    if (hits(wb_adr_i, clock_gating_pkg::SLEEP_GATE_1_OFFSET)) begin
      read_word = sleep_clock_gate_1;
    end
    if (hits(wb_adr_i, clock_gating_pkg::DEEP_GATE_0_OFFSET)) begin
      read_word = deep_sleep_clock_gate_0;
    end
    if (hits(wb_adr_i, clock_gating_pkg::DEEP_GATE_1_OFFSET)) begin
      read_word = deep_sleep_clock_gate_1;
    end
    if (hits(wb_adr_i, clock_gating_pkg::MODE_CTRL_OFFSET)) begin
      read_word = run_clock_config;
    end
    if (hits(wb_adr_i, clock_gating_pkg::STATUS_OFFSET)) begin
      read_word = status_word;
    end
  end

  // ***************************************************************
  // Bus answer
  // ***************************************************************
  // One wait state; ack or err drops the cycle after it is given
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= request & ~wb_ack_o & ~wb_err_o & mapped;
      wb_err_o <= request & ~wb_ack_o & ~wb_err_o & ~mapped;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= clock_gating_pkg::ZERO_WORD;
    end else if (request & ~wb_ack_o & ~wb_err_o) begin
      wb_dat_o <= read_word;
    end
  end

endmodule : peripheral_clock_gating

// ---- tb/clock_gating_chk.sv ----
// Port checks for the clock-gating control block
module clock_gating_chk (
  input wire logic                       ref_clk,
  input wire logic                       rst_b,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [11:0]                wb_adr_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic                       wb_err_o,
  input wire logic                       unit_access_valid,
  input wire clock_gating_pkg::unit_id_t unit_access_id,
  input wire logic                       unit_access_fault,
  input wire logic                       unit_access_grant,
  input wire logic                       watchdog_clock_enable,
  input wire logic                       gp_timer_unit0_clock_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_BUS_ANSWER: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=>
    wb_ack_o != wb_err_o) else $error("Bus left unanswered");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack held too long");
  AST_UNMAPPED: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o &&
    wb_adr_i[11:8] == 4'h3 |=> wb_err_o) else $error("Unmapped not refused");
  AST_DEEP_RSVD: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[11:2] == 10'h048 |-> (wb_dat_o & 32'hF8FFFFF7) == 32'h0)
    else $error("Deep gate reserved bits set");
  AST_RUN1_RSVD: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[11:2] == 10'h041 |-> wb_dat_o[31:20] == 12'h000)
    else $error("Run gate reserved bits set");
  AST_WDOG_FAULT: assert property (
    unit_access_valid && !watchdog_clock_enable &&
    unit_access_id == clock_gating_pkg::UNIT_WATCHDOG |=>
    unit_access_fault && !unit_access_grant) else $error("No fault");
  AST_TIMER_GRANT: assert property (unit_access_valid &&
    unit_access_id == clock_gating_pkg::UNIT_GP_GP_TIMER_UNIT0_CLOCK_ENABLE &&
    gp_timer_unit0_clock_enable |=> unit_access_grant && !unit_access_fault)
    else $error("No grant");
  AST_IDLE_QUIET: assert property (!unit_access_valid |=>
    !unit_access_fault && !unit_access_grant) else $error("Stray answer");
  AST_RESET_OFF: assert property ($rose(rst_b) |->
    !watchdog_clock_enable && !gp_timer_unit0_clock_enable)
    else $error("Clock on after reset");
endmodule : clock_gating_chk
bind peripheral_clock_gating clock_gating_chk chk (.*);

// ---- tb/peripheral_clock_gating_bench.sv ----
// Self-checking bench for the clock-gating control block
module peripheral_clock_gating_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, unit_access_valid;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic wb_ack_o, wb_err_o, unit_access_fault, unit_access_grant, er;
  clock_gating_pkg::power_mode_t power_mode;
  clock_gating_pkg::unit_id_t unit_access_id;
  logic fieldbus_unit0_clock_enable, fieldbus_unit1_clock_enable;
  logic fieldbus_unit2_clock_enable, watchdog_clock_enable;
  logic gp_timer_unit0_clock_enable, gp_timer_unit1_clock_enable;
  logic gp_timer_unit2_clock_enable, gp_timer_unit3_clock_enable;
  logic two_wire_unit0_clock_enable, sync_serial_unit0_clock_enable;
  logic sync_serial_unit1_clock_enable, async_serial_unit0_clock_enable;
  int miscompares, checked;
  wire logic [11:0] en = {fieldbus_unit0_clock_enable,
    fieldbus_unit1_clock_enable, fieldbus_unit2_clock_enable,
    watchdog_clock_enable, gp_timer_unit0_clock_enable,
    gp_timer_unit1_clock_enable, gp_timer_unit2_clock_enable,
    gp_timer_unit3_clock_enable, two_wire_unit0_clock_enable,
    sync_serial_unit0_clock_enable, sync_serial_unit1_clock_enable,
    async_serial_unit0_clock_enable};
  peripheral_clock_gating dut (.*);
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic cmp(input string what, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  // Reads at an edge see pre-edge values, so ack is seen as sampled
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // The wait ends on ack or err; only the bench watchdog ends one that gets no answer
    do begin
      @(posedge ref_clk);
    end while (!(wb_ack_o || wb_err_o));
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : bus
  task automatic probe(input clock_gating_pkg::unit_id_t id, input logic f);
    @(posedge ref_clk);
    unit_access_valid <= 1'h1;
    unit_access_id <= id;
    @(posedge ref_clk);
    unit_access_valid <= 1'h0;
    @(posedge ref_clk);
    cmp("fault grant", {30'h0, f, !f}, {30'h0, unit_access_fault,
        unit_access_grant});
  endtask : probe
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_reset();
    bus(1'h0, 12'h104, 32'h0, 4'hF);
    cmp("run gate 1", 32'h0, rd);
    bus(1'h0, 12'h120, 32'h0, 4'hF);
    cmp("deep gate 0", 32'h0, rd);
    cmp("enables", 32'h0, {20'h0, en});
    probe(clock_gating_pkg::UNIT_WATCHDOG, 1'h1);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_run_gate();
    bus(1'h1, 12'h104, 32'hFFFFFFFF, 4'hF);
    bus(1'h0, 12'h104, 32'h0, 4'hF);
    cmp("run gate 1", 32'h000F1031, rd);
    cmp("enables", 32'h0FF, {20'h0, en});
    bus(1'h1, 12'h104, 32'h0, 4'h4);
    bus(1'h0, 12'h104, 32'h0, 4'hF);
    cmp("run gate 1", 32'h00001031, rd);
    cmp("enables", 32'h00F, {20'h0, en});
    probe(clock_gating_pkg::UNIT_GP_GP_TIMER_UNIT0_CLOCK_ENABLE, 1'h1);
    probe(clock_gating_pkg::UNIT_ASYNC_SERIAL0, 1'h0);
    bus(1'h1, 12'h104, rd | 32'h00010000, 4'hF);
    bus(1'h0, 12'h104, 32'h0, 4'hF);
    cmp("run gate 1", 32'h00011031, rd);
    probe(clock_gating_pkg::UNIT_GP_GP_TIMER_UNIT0_CLOCK_ENABLE, 1'h0);
    $display("test_run_gate done");
  endtask : test_run_gate
  task automatic test_deep();
    bus(1'h1, 12'h120, 32'hFFFFFFFF, 4'hF);
    bus(1'h0, 12'h120, 32'h0, 4'hF);
    cmp("deep gate 0", 32'h07000008, rd);
    cmp("enables", 32'h08F, {20'h0, en});
    power_mode <= clock_gating_pkg::MODE_DEEP_SLEEP;
    bus(1'h1, 12'h200, 32'h1, 4'hF);
    repeat (2) @(posedge ref_clk);
    cmp("enables", 32'hF00, {20'h0, en});
    probe(clock_gating_pkg::UNIT_WATCHDOG, 1'h0);
    bus(1'h0, 12'h204, 32'h0, 4'hF);
    cmp("status", 32'h0002000F, rd);
    power_mode <= clock_gating_pkg::MODE_SLEEP;
    repeat (2) @(posedge ref_clk);
    cmp("enables", 32'h000, {20'h0, en});
    power_mode <= clock_gating_pkg::MODE_RUN;
    repeat (2) @(posedge ref_clk);
    cmp("enables", 32'h08F, {20'h0, en});
    probe(clock_gating_pkg::UNIT_WATCHDOG, 1'h1);
    $display("test_deep done");
  endtask : test_deep
  task automatic test_unmapped();
    bus(1'h1, 12'h300, 32'hFFFFFFFF, 4'hF);
    cmp("write error", 32'h1, {31'h0, er});
    bus(1'h0, 12'h300, 32'h0, 4'hF);
    cmp("read data", 32'h0, rd);
    $display("test_unmapped done");
  endtask : test_unmapped
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, unit_access_valid} = 5'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 48'h0;
    power_mode = clock_gating_pkg::MODE_RUN;
    unit_access_id = clock_gating_pkg::UNIT_FIELDBUS0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'h1;
    test_reset();
    test_run_gate();
    test_deep();
    test_unmapped();
    close_out();
  end
endmodule : peripheral_clock_gating_bench
